// File: design/ddcp_defs.svh
// Purpose: named offsets, field positions and reset values of the port block
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef DDCP_DEFS_SVH
`define DDCP_DEFS_SVH

// register offsets
`define DDCP_OFS_CFG_A      8'h1a
`define DDCP_OFS_LNK_A      8'h1b
`define DDCP_OFS_CFG_B      8'h1c
`define DDCP_OFS_LNK_B      8'h1d
`define DDCP_OFS_CLK        8'h1e
`define DDCP_REG_RESET      8'h00

// link control fields
`define DDCP_LNK_EN_BIT     7
`define DDCP_LNK_CHMODE_BIT 0

// output config fields
`define DDCP_CFG_CH_LSB     1
`define DDCP_CFG_AGC_A_BIT  1
`define DDCP_CFG_AGC_B_BIT  2
`define DDCP_CFG_CONC_BIT   5

// port clock control fields
`define DDCP_CLK_MASTER_BIT 0
`define DDCP_CLK_DIV_LSB    1

// data layout
`define DDCP_RSSI_PAD       4'h0
`define DDCP_LINK_PAD       8'h00
`define DDCP_DIV_ONE        2'h0

`endif

// File: design/ddcp_output_port.sv
// Purpose: two 16-bit parallel output ports with request/accept handshake
// Assumes: sources present one-cycle valid pulses on the core clock
// Notes:   all port state lives on the core clock, paced by port clock ticks
`timescale 1ns/1ps
`include "ddcp_defs.svh"

module ddcp_output_port
  import ddcp_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        port_ctrl_access_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [3:0]  chan_valid_i,
  input  wire logic [63:0] chan_i_i,
  input  wire logic [63:0] chan_q_i,
  input  wire logic [1:0]  agc_valid_i,
  input  wire logic [31:0] agc_i_i,
  input  wire logic [31:0] agc_q_i,
  input  wire logic [23:0] agc_gain_i,
  input  wire logic [7:0]  link_a_byte_i,
  input  wire logic [7:0]  link_b_byte_i,
  input  wire logic        pclk_pin_i,
  output logic             pclk_pin_o,
  output logic             pclk_pin_oe_o,
  input  wire logic        port_a_accept_input_i,
  input  wire logic        port_b_accept_input_i,
  output logic             port_a_req_o,
  output logic      [15:0] port_a_data_o,
  output logic             port_a_i_flag_o,
  output logic      [1:0]  port_a_source_tag_o,
  output logic             port_b_req_o,
  output logic      [15:0] port_b_data_o,
  output logic             port_b_i_flag_o,
  output logic      [1:0]  port_b_source_tag_o
);

  logic [7:0]  cfg_reg      [2];
  logic [7:0]  lnk_reg      [2];
  logic [7:0]  clk_reg;
  logic [7:0]  rdata;
  logic [7:0]  next_cfg     [2];
  logic [7:0]  next_lnk     [2];
  logic [7:0]  next_clk;
  logic [7:0]  next_rdata;
  logic        pclk_rise;
  logic        pclk_fall;
  logic [1:0]  accept_pin;
  logic [7:0]  link_byte    [2];
  logic [15:0] data_q       [2];
  logic        flag_q       [2];
  logic [1:0]  tag_q        [2];
  logic        req_q        [2];

  ////////////////////////////////////////////////////////////////////////////
  // port clock source
  ddcp_pclk_gen u_pclk (
    .core_clk_i    (core_clk_i),
    .reset_n_i     (reset_n_i),
    .clk_en_i      (clk_en_i),
    .master_i      (clk_reg[`DDCP_CLK_MASTER_BIT]),
    .div_i         (clk_reg[`DDCP_CLK_DIV_LSB +: 2]),
    .pclk_pin_i    (pclk_pin_i),
    .pclk_pin_o    (pclk_pin_o),
    .pclk_pin_oe_o (pclk_pin_oe_o),
    .rise_o        (pclk_rise),
    .fall_o        (pclk_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file, writes only while port control access is open
  always_comb begin
    next_cfg = cfg_reg;
    next_lnk = lnk_reg;
    next_clk = clk_reg;
    if (reg_wr_i && port_ctrl_access_i) begin
      unique case (reg_addr_i)
        `DDCP_OFS_CFG_A: next_cfg[0] = reg_wdata_i;
        `DDCP_OFS_LNK_A: next_lnk[0] = reg_wdata_i;
        `DDCP_OFS_CFG_B: next_cfg[1] = reg_wdata_i;
        `DDCP_OFS_LNK_B: next_lnk[1] = reg_wdata_i;
        `DDCP_OFS_CLK:   next_clk    = reg_wdata_i;
        default:         next_clk    = clk_reg;
      endcase
    end
    unique case (reg_addr_i)
      `DDCP_OFS_CFG_A: next_rdata = cfg_reg[0];
      `DDCP_OFS_LNK_A: next_rdata = lnk_reg[0];
      `DDCP_OFS_CFG_B: next_rdata = cfg_reg[1];
      `DDCP_OFS_LNK_B: next_rdata = lnk_reg[1];
      `DDCP_OFS_CLK:   next_rdata = clk_reg;
      default:         next_rdata = `DDCP_REG_RESET;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cfg_reg <= '{`DDCP_REG_RESET, `DDCP_REG_RESET};
      lnk_reg <= '{`DDCP_REG_RESET, `DDCP_REG_RESET};
      clk_reg <= `DDCP_REG_RESET;
      rdata   <= `DDCP_REG_RESET;
    end else if (clk_en_i) begin
      cfg_reg <= next_cfg;
      lnk_reg <= next_lnk;
      clk_reg <= next_clk;
      rdata   <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;
  assign accept_pin  = {port_b_accept_input_i, port_a_accept_input_i};
  assign link_byte[0] = link_a_byte_i;
  assign link_byte[1] = link_b_byte_i;

  ////////////////////////////////////////////////////////////////////////////
  // one sequencer per port
  for (genvar p = 0; p < 2; p++) begin : g_port
    ddcp_state_type state;
    ddcp_state_type next_state;
    logic [3:0]  ch_pend;
    logic [3:0]  next_ch_pend;
    logic [15:0] ch_i [4];
    logic [15:0] ch_q [4];
    logic [1:0]  agc_pend;
    logic [1:0]  next_agc_pend;
    logic [1:0]  rssi_pend;
    logic [1:0]  next_rssi_pend;
    logic [15:0] ag_i [2];
    logic [15:0] ag_q [2];
    logic [11:0] gain [2];
    logic [15:0] next_ch_i [4];
    logic [15:0] next_ch_q [4];
    logic [15:0] next_ag_i [2];
    logic [15:0] next_ag_q [2];
    logic [11:0] next_gain [2];
    logic [15:0] cur_q;
    logic [15:0] next_cur_q;
    logic [11:0] cur_rssi;
    logic [11:0] next_cur_rssi;
    logic        with_rssi;
    logic        next_with_rssi;
    logic [15:0] next_data;
    logic        next_flag;
    logic [1:0]  next_tag;
    logic        next_req;
    logic        acc_s1;
    logic        acc_s2;
    logic        acc_smp;
    logic [3:0]  clr_ch;
    logic [1:0]  clr_agc;
    logic [3:0]  avail_ch;
    logic [1:0]  avail_agc;
    logic [1:0]  pick_c;
    logic        pick_s;
    logic        chmode;
    logic        en;
    logic        conc;

    assign chmode    = lnk_reg[p][`DDCP_LNK_CHMODE_BIT];
    assign en        = lnk_reg[p][`DDCP_LNK_EN_BIT];
    assign conc      = cfg_reg[p][`DDCP_CFG_CONC_BIT];
    // source selection per mode
    assign avail_ch  = ch_pend & cfg_reg[p][`DDCP_CFG_CH_LSB +: 4]
                       & {4{chmode}};
    assign avail_agc = agc_pend & {cfg_reg[p][`DDCP_CFG_AGC_B_BIT],
                       cfg_reg[p][`DDCP_CFG_AGC_A_BIT]} & {2{~chmode}};
    assign pick_s    = ~avail_agc[0];

    // lowest pending channel wins
    always_comb begin
      pick_c = 2'h0;
      for (int c = 3; c >= 0; c--) begin
        if (avail_ch[c]) begin
          pick_c = 2'(c);
        end
      end
    end

    // sample capture: set wins over the clear of a started word
    always_comb begin
      next_ch_i      = ch_i;
      next_ch_q      = ch_q;
      next_ag_i      = ag_i;
      next_ag_q      = ag_q;
      next_gain      = gain;
      next_ch_pend   = (ch_pend & ~clr_ch) | (chan_valid_i & {4{en}});
      next_agc_pend  = (agc_pend & ~clr_agc) | (agc_valid_i & {2{en}});
      next_rssi_pend = rssi_pend & ~clr_agc;
      for (int c = 0; c < 4; c++) begin
        if (chan_valid_i[c] && en) begin
          next_ch_i[c] = chan_i_i[c*16 +: 16];
          next_ch_q[c] = chan_q_i[c*16 +: 16];
        end
      end
      for (int s = 0; s < 2; s++) begin
        if (agc_valid_i[s] && en) begin
          next_ag_i[s] = agc_i_i[s*16 +: 16];
          next_ag_q[s] = agc_q_i[s*16 +: 16];
          next_gain[s] = agc_gain_i[s*12 +: 12];
          if (agc_gain_i[s*12 +: 12] != gain[s]) begin
            next_rssi_pend[s] = 1'b1;
          end
        end
      end
    end

    // word sequencer, advanced on rising port clock only
    always_comb begin
      next_state     = state;
      next_data      = data_q[p];
      next_flag      = flag_q[p];
      next_tag       = tag_q[p];
      next_req       = req_q[p];
      next_cur_q     = cur_q;
      next_cur_rssi  = cur_rssi;
      next_with_rssi = with_rssi;
      clr_ch         = 4'h0;
      clr_agc        = 2'h0;
      if (pclk_rise) begin
        unique case (state)
          ST_QWORD: begin
            next_data  = cur_q;
            next_flag  = 1'b0;
            next_state = with_rssi ? ST_RSSI : ST_IDLE;
          end
          ST_RSSI: begin
            next_data  = {cur_rssi, `DDCP_RSSI_PAD};
            next_tag   = {1'b1, tag_q[p][0]};
            next_state = ST_IDLE;
          end
          ST_IDLE: begin
            next_flag = 1'b0;
            if (en && acc_smp && req_q[p] && avail_ch != 4'h0) begin
              clr_ch[pick_c] = 1'b1;
              next_flag      = 1'b1;
              next_tag       = pick_c;
              next_cur_q     = ch_q[pick_c];
              next_with_rssi = 1'b0;
              if (conc) begin
                next_data = {ch_i[pick_c][15:8], ch_q[pick_c][15:8]};
              end else begin
                next_data  = ch_i[pick_c];
                next_state = ST_QWORD;
              end
            end else if (en && acc_smp && req_q[p] && avail_agc != 2'h0) begin
              clr_agc[pick_s] = 1'b1;
              next_flag       = 1'b1;
              next_tag        = {1'b0, pick_s};
              next_data       = ag_i[pick_s];
              next_cur_q      = ag_q[pick_s];
              next_cur_rssi   = ~gain[pick_s];
              next_with_rssi  = rssi_pend[pick_s];
              next_state      = ST_QWORD;
            end
          end
          default: next_state = ST_IDLE;
        endcase
        next_req = en && ((avail_ch & ~clr_ch) != 4'h0
                   || (avail_agc & ~clr_agc) != 2'h0
                   || next_state != ST_IDLE);
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
        state     <= ST_IDLE;
        ch_pend   <= 4'h0;
        agc_pend  <= 2'h0;
        rssi_pend <= 2'h0;
        ch_i      <= '{4{16'h0000}};
        ch_q      <= '{4{16'h0000}};
        ag_i      <= '{2{16'h0000}};
        ag_q      <= '{2{16'h0000}};
        gain      <= '{2{12'h000}};
        cur_q     <= 16'h0000;
        cur_rssi  <= 12'h000;
        with_rssi <= 1'b0;
        data_q[p] <= 16'h0000;
        flag_q[p] <= 1'b0;
        tag_q[p]  <= 2'h0;
        req_q[p]  <= 1'b0;
        acc_s1    <= 1'b0;
        acc_s2    <= 1'b0;
        acc_smp   <= 1'b0;
      end else if (clk_en_i) begin
        state     <= next_state;
        ch_pend   <= next_ch_pend;
        agc_pend  <= next_agc_pend;
        rssi_pend <= next_rssi_pend;
        ch_i      <= next_ch_i;
        ch_q      <= next_ch_q;
        ag_i      <= next_ag_i;
        ag_q      <= next_ag_q;
        gain      <= next_gain;
        cur_q     <= next_cur_q;
        cur_rssi  <= next_cur_rssi;
        with_rssi <= next_with_rssi;
        data_q[p] <= next_data;
        flag_q[p] <= next_flag;
        tag_q[p]  <= next_tag;
        req_q[p]  <= next_req;
        acc_s1    <= accept_pin[p];
        acc_s2    <= acc_s1;
        if (pclk_fall) begin
          acc_smp <= acc_s2;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins: low byte shared with the link lane when parallel output is off
  always_comb begin
    port_a_data_o = lnk_reg[0][`DDCP_LNK_EN_BIT] ? data_q[0]
                    : {`DDCP_LINK_PAD, link_byte[0]};
    port_b_data_o = lnk_reg[1][`DDCP_LNK_EN_BIT] ? data_q[1]
                    : {`DDCP_LINK_PAD, link_byte[1]};
    port_a_i_flag_o     = flag_q[0];
    port_b_i_flag_o     = flag_q[1];
    port_a_source_tag_o = tag_q[0];
    port_b_source_tag_o = tag_q[1];
    port_a_req_o        = req_q[0];
    port_b_req_o        = req_q[1];
  end

endmodule

// File: design/ddcp_pclk_gen.sv
// Purpose: port clock source and edge ticks in the core clock domain
// Assumes: slave clock well below half the core rate
// Notes:   divide-by-one passes the core clock straight to the pin
`timescale 1ns/1ps
`include "ddcp_defs.svh"

module ddcp_pclk_gen (
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       clk_en_i,
  input  wire logic       master_i,
  input  wire logic [1:0] div_i,
  input  wire logic       pclk_pin_i,
  output logic            pclk_pin_o,
  output logic            pclk_pin_oe_o,
  output logic            rise_o,
  output logic            fall_o
);

  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [2:0] half;
  logic       phase;
  logic       next_phase;
  logic       sync1;
  logic       sync2;
  logic       sync3;

  ////////////////////////////////////////////////////////////////////////////
  // master divider: period of 2**div core cycles
  always_comb begin
    half       = 3'((4'h1 << div_i) >> 1);
    next_cnt   = (cnt + 3'h1) & 3'((4'h1 << div_i) - 4'h1);
    next_phase = next_cnt < half;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      cnt   <= 3'h0;
      phase <= 1'b0;
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else if (clk_en_i) begin
      cnt   <= next_cnt;
      phase <= next_phase;
      sync1 <= pclk_pin_i;  // slave pin, two-stage synchroniser
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive and edge ticks
  always_comb begin
    pclk_pin_oe_o = master_i;
    pclk_pin_o    = (div_i == `DDCP_DIV_ONE) ? core_clk_i : phase;
    // in master mode ticks mark the core edge on which the pin itself rises or falls, but at divide-by-one both fire every cycle;
    // slave ticks follow the synchroniser
    if (master_i) begin
      rise_o = clk_en_i && (next_cnt == 3'h0);
      fall_o = clk_en_i && ((div_i == `DDCP_DIV_ONE) || (next_cnt == half));
    end else begin
      rise_o = clk_en_i && sync2 && !sync3;
      fall_o = clk_en_i && !sync2 && sync3;
    end
  end

endmodule

// File: design/ddcp_pkg.sv
// Purpose: shared types of the parallel output port block
// Assumes: nothing
// Notes:   constants live in ddcp_defs.svh
package ddcp_pkg;

  // word sequencer of one port, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_QWORD = 3'b010,
    ST_RSSI  = 3'b100
  } ddcp_state_type;

endpackage

// File: dv/ddcp_assertions.sv
// Purpose: port-level properties of the parallel output port
// Assumes: clk_en_i held high by the bench
// Notes:   mirrors follow accepted register writes only
`timescale 1ns/1ps

module ddcp_checker (
  input wire logic        core_clk_i,
  input wire logic        reset_n_i,
  input wire logic        port_ctrl_access_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  link_a_byte_i,
  input wire logic        pclk_pin_o,
  input wire logic        pclk_pin_oe_o,
  input wire logic        port_a_req_o,
  input wire logic [15:0] port_a_data_o,
  input wire logic        port_a_i_flag_o,
  input wire logic [1:0]  port_a_source_tag_o
);
  logic [7:0] lnk;
  logic [7:0] pck;
  logic [3:0] cnt;
  logic       wok;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // accepted write strobe
  assign wok = reg_wr_i && port_ctrl_access_i;

  // mirror link control a and clock control, count quiet cycles
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      lnk <= 8'h00;
      pck <= 8'h00;
      cnt <= 4'h0;
    end else begin
      if (wok && reg_addr_i == 8'h1b)
        lnk <= reg_wdata_i;
      if (wok && reg_addr_i == 8'h1e)
        pck <= reg_wdata_i;
      cnt <= wok ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
    end
  end

  ////////////////////////////////////////
  property p_rst;
    $rose(reset_n_i) |-> !pclk_pin_oe_o && !port_a_req_o &&
      !port_a_i_flag_o && port_a_source_tag_o == 2'h0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not idle after reset");
  property p_oe;
    cnt >= 4'h2 |-> pclk_pin_oe_o == pck[0];
  endproperty
  a_oe: assert property (p_oe)
    else $error("clock pin drive differs from master bit");
  property p_ref;
    reg_wr_i && !port_ctrl_access_i |=> $stable(pclk_pin_oe_o);
  endproperty
  a_ref: assert property (p_ref)
    else $error("write without access changed the port");
  property p_lane;
    cnt >= 4'h2 && !lnk[7] && $stable(link_a_byte_i) |->
      port_a_data_o[7:0] == link_a_byte_i;
  endproperty
  a_lane: assert property (p_lane)
    else $error("disabled port low byte is not the link lane");
  property p_req;
    $rose(port_a_i_flag_o) |-> $past(port_a_req_o);
  endproperty
  a_req: assert property (p_req)
    else $error("word started without request");
  property p_rssi;
    lnk[7] && !lnk[0] && port_a_source_tag_o[1] |->
      !port_a_i_flag_o && port_a_data_o[3:0] == 4'h0;
  endproperty
  a_rssi: assert property (p_rssi)
    else $error("strength word malformed");
  property p_div2;
    pck == 8'h03 && cnt == 4'hf |-> pclk_pin_o != $past(pclk_pin_o);
  endproperty
  a_div2: assert property (p_div2)
    else $error("port clock not core clock over two");
  property p_div4;
    pck == 8'h05 && cnt == 4'hf |-> pclk_pin_o != $past(pclk_pin_o, 2);
  endproperty
  a_div4: assert property (p_div4)
    else $error("port clock not core clock over four");

  c_rssi: cover property (lnk[7] && !lnk[0] && port_a_source_tag_o[1]);
  c_mst: cover property (pck[0] && cnt == 4'hf);
  c_flag: cover property ($rose(port_a_i_flag_o));
endmodule

bind ddcp_output_port ddcp_checker i_ddcp_checker (
  .core_clk_i, .reset_n_i, .port_ctrl_access_i, .reg_wr_i, .reg_addr_i,
  .reg_wdata_i, .link_a_byte_i, .pclk_pin_o, .pclk_pin_oe_o,
  .port_a_req_o, .port_a_data_o, .port_a_i_flag_o, .port_a_source_tag_o
);

// File: dv/ddcp_rx_model.sv
// Purpose: receiver on one output port, slave clock source
// Assumes: bench stops the clock before master mode
// Notes:   logs {req, flag, tag, data} at every port clock rise
`timescale 1ns/1ps

module ddcp_rx_model (
  input  wire logic        run_i,
  input  wire logic        stall_i,
  input  wire logic        pclk_i,
  input  wire logic        req_i,
  input  wire logic [15:0] data_i,
  input  wire logic        i_flag_i,
  input  wire logic [1:0]  tag_i,
  output logic             pclk_o,
  output logic             accept_o
);
  logic [19:0] words[$];

  // slave clock near 24 mhz, unrelated to core, still when stopped
  initial begin
    pclk_o = 1'b0;
    forever begin
      #21;
      pclk_o = run_i ? ~pclk_o : 1'b0;
    end
  end

  // accept moves after the rise, steady over the sampling fall
  always @(posedge pclk_i) begin
    accept_o <= #1 ~stall_i;
    words.push_back({req_i, i_flag_i, tag_i, data_i});
  end
endmodule

// File: dv/tb.sv
// Purpose: self-checking bench for the parallel output port
// Assumes: receiver models supply accept and the slave clock
// Notes:   words are judged as logged by the receivers
`timescale 1ns/1ps

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  fails++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb;
  logic        clk, rst_n, acc, wr, run, stall_a, stall_b, pin_w;
  logic        pin_o, oe, m_pclk, acc_a, acc_b, req_a, req_b;
  logic        fl_a, fl_b;
  logic [1:0]  tag_a, tag_b, av;
  logic [3:0]  cv;
  logic [7:0]  addr, wdat, rdat, lka, lkb;
  logic [11:0] g;
  logic [15:0] dat_a, dat_b;
  logic [23:0] ag;
  logic [31:0] ai, aq;
  logic [63:0] ci, cq;
  time         t0;
  int          fails, num_checks;

  assign pin_w = oe ? pin_o : m_pclk;

  ddcp_output_port i_ddcp_output_port (
    .core_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1),
    .port_ctrl_access_i(acc), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdat), .reg_rdata_o(rdat), .chan_valid_i(cv),
    .chan_i_i(ci), .chan_q_i(cq), .agc_valid_i(av), .agc_i_i(ai),
    .agc_q_i(aq), .agc_gain_i(ag), .link_a_byte_i(lka),
    .link_b_byte_i(lkb), .pclk_pin_i(pin_w), .pclk_pin_o(pin_o),
    .pclk_pin_oe_o(oe), .port_a_accept_input_i(acc_a),
    .port_b_accept_input_i(acc_b), .port_a_req_o(req_a),
    .port_a_data_o(dat_a), .port_a_i_flag_o(fl_a),
    .port_a_source_tag_o(tag_a), .port_b_req_o(req_b),
    .port_b_data_o(dat_b), .port_b_i_flag_o(fl_b),
    .port_b_source_tag_o(tag_b)
  );
  ddcp_rx_model i_rx_a (
    .run_i(run), .stall_i(stall_a), .pclk_i(pin_w), .req_i(req_a),
    .data_i(dat_a), .i_flag_i(fl_a), .tag_i(tag_a), .pclk_o(m_pclk),
    .accept_o(acc_a)
  );
  ddcp_rx_model i_rx_b (
    .run_i(1'b0), .stall_i(stall_b), .pclk_i(pin_w), .req_i(req_b),
    .data_i(dat_b), .i_flag_i(fl_b), .tag_i(tag_b), .pclk_o(),
    .accept_o(acc_b)
  );

  ////////////////////////////////////////
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdat = d;
    wr = 1'b1;
    wait_c(1);
    wr = 1'b0;
    wait_c(1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    wait_c(2);
    `CHK("reg", e, rdat)
  endtask
  // channel c carries {s, c, 0} as i and {~s, c, 0} as q
  task automatic smp(input logic [3:0] m, input logic [7:0] s);
    for (int c = 0; c < 4; c++) begin
      ci[c*16+:16] = {s, c[3:0], 4'h0};
      cq[c*16+:16] = {~s, c[3:0], 4'h0};
    end
    cv = m;
    wait_c(1);
    cv = 4'h0;
    wait_c(1);
  endtask
  task automatic agc(input int s, input logic [11:0] gn);
    ai[s*16+:16] = {4'h6, gn};
    aq[s*16+:16] = {4'h9, gn};
    ag[s*12+:12] = gn;
    av[s] = 1'b1;
    wait_c(1);
    av = 2'h0;
  endtask
  task automatic clr();
    i_rx_a.words.delete();
    i_rx_b.words.delete();
  endtask
  task automatic drain();
    wait_c(20);
    for (int n = 0; n < 2000 && (req_a !== 1'b0 || req_b !== 1'b0); n++)
      @(posedge clk);
    wait_c(40);
    `CHK("req a", 1'b0, req_a)
    `CHK("req b", 1'b0, req_b)
  endtask
  // word n after the first flagged word of port a or b
  task automatic wchk(input bit b, input int n, input logic [18:0] e,
                      input logic [18:0] m = 19'h7ffff);
    logic [19:0] q[$];
    int          k;
    q = b ? i_rx_b.words : i_rx_a.words;
    k = 0;
    while (k < q.size() && q[k][18] !== 1'b1)
      k++;
    `CHK("word", e, q[k+n][18:0] & m)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // watchdog, the run needs well under 40 us
  initial begin
    #200us;
    fails++;
    close_out();
  end

  initial begin
    {rst_n, wr, cv, av, stall_a, stall_b} = '0;
    {addr, wdat, ci, cq, ai, aq, ag} = '0;
    {acc, run, lka, lkb} = {2'b11, 8'h3c, 8'hc3};
    wait_c(3);
    rst_n = 1'b1;
    // reset values, refused and unmapped writes
    for (int a = 8'h1a; a <= 8'h1f; a++)
      rd_chk(a[7:0], 8'h00);
    acc = 1'b0;
    wr_reg(8'h1a, 8'h5a);
    wr_reg(8'h1e, 8'h01);
    acc = 1'b1;
    wr_reg(8'h1f, 8'h5a);
    rd_chk(8'h1a, 8'h00);
    rd_chk(8'h1e, 8'h00);
    rd_chk(8'h1f, 8'h00);
    wr_reg(8'h1c, 8'ha5);
    rd_chk(8'h1c, 8'ha5);
    // disabled ports show the link lanes and ignore samples
    smp(4'hf, 8'h01);
    wait_c(40);
    `CHK("lane a", 16'h003c, dat_a)
    `CHK("lane b", 16'h00c3, dat_b)
    `CHK("req off", 1'b0, req_a)
    // interleaved on a: channels 1 and 2, stalled, 2 overwritten
    wr_reg(8'h1b, 8'h81);
    wr_reg(8'h1a, 8'h0c);
    stall_a = 1'b1;
    smp(4'he, 8'h11);
    smp(4'h4, 8'h22);
    wait_c(40);
    `CHK("req stall", 1'b1, req_a)
    `CHK("flag stall", 1'b0, fl_a)
    clr();
    stall_a = 1'b0;
    drain();
    wchk(0, 0, {1'b1, 2'h1, 16'h1110});
    wchk(0, 1, {1'b0, 2'h1, 16'hee10});
    wchk(0, 2, {1'b1, 2'h2, 16'h2220});
    wchk(0, 3, {1'b0, 2'h2, 16'hdd20});
    // concurrent on b: channels 0 and 3 back to back
    wr_reg(8'h1d, 8'h81);
    wr_reg(8'h1c, 8'h32);
    stall_b = 1'b1;
    smp(4'h9, 8'h44);
    wait_c(40);
    clr();
    stall_b = 1'b0;
    drain();
    wchk(1, 0, {1'b1, 2'h0, 16'h44bb});
    wchk(1, 1, {1'b1, 2'h3, 16'h44bb});
    // gain mode on a, both stages, strength word on a new gain
    wr_reg(8'h1b, 8'h80);
    wr_reg(8'h1a, 8'h06);
    for (int s = 0; s < 2; s++) begin
      clr();
      g = 12'h3c5 + 12'(s);
      agc(s, g);
      drain();
      wchk(0, 0, {1'b1, 1'b0, s[0], 4'h6, g});
      wchk(0, 1, {1'b0, 1'b0, s[0], 4'h9, g});
      wchk(0, 2, {1'b0, 1'b1, s[0], ~g, 4'h0});
    end
    clr();
    agc(0, 12'h3c5);
    drain();
    wchk(0, 1, {1'b0, 2'h0, 4'h9, 12'h3c5});
    wchk(0, 2, 19'h0, 19'h60000);
    // master clock at every divider code, then slave again
    run = 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h1e, {5'h0, c[1:0], 1'b1});
      wait_c(30);
      `CHK("oe", 1'b1, oe)
      @(posedge pin_w);
      t0 = $time;
      @(posedge pin_w);
      `CHK("period", 64'(5 << c), $time - t0)
      wait_c(1);
    end
    wr_reg(8'h1e, 8'h00);
    wait_c(3);
    `CHK("oe slave", 1'b0, oe)
    close_out();
  end
endmodule
